// [src/ptm_array_block.sv]
// Product-term array block top: config store, clears, macrocells
`timescale 1ns/1ns
`include "ptm_params.svh"
module ptm_array_block #(
  parameter int NMC = `NUM_MC,
  parameter int NLOC = `NUM_LOC,
  parameter int NFB = `NUM_FB
) (
  input wire logic clock,
  input wire logic nrst,
  input wire ptm_pkg::addr_t addr,
  input wire ptm_pkg::word_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output ptm_pkg::word_t rd_data,
  input wire logic [NLOC-1:0] local_in,
  input wire logic [1:0] ctrl_in,
  input wire logic [`NUM_DCLK-1:0] ded_clk_pin,
  input wire logic [`NUM_GLB-1:0] global_pin,
  output logic [NMC-1:0] mc_out,
  output logic io_reg_out
);
  import ptm_pkg::*;

  localparam int NT = NLOC + NFB;
  localparam int NP = `NUM_DCLK + `NUM_GLB;

  // =====================================================
  // Pin synchronisers
  logic [NP-1:0] pin_s1_r; // First stage, read only by second
  logic [NP-1:0] pin_s2_r; // Safe level
  logic [NP-1:0] pin_s3_r; // Previous level for edges
  logic [NP-1:0] pin_s1_nxt;
  logic [NP-1:0] pin_s2_nxt;
  logic [NP-1:0] pin_s3_nxt;
  logic [`NUM_DCLK-1:0] clk_edge; // Rising edge of each clock pin
  logic [`NUM_GLB-1:0] glb; // Synchronised globals

  // Next values of the synchroniser chain
  always_comb begin
    pin_s1_nxt = {global_pin, ded_clk_pin}; // [R4]
    pin_s2_nxt = pin_s1_r;
    pin_s3_nxt = pin_s2_r;
  end

  // Chain registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
      pin_s3_r <= pin_s3_nxt;
    end
  end

  // Edge and level decode
  always_comb begin
    clk_edge = pin_s2_r[`NUM_DCLK-1:0] & ~pin_s3_r[`NUM_DCLK-1:0]; // [R11]
    glb = pin_s2_r[NP-1:`NUM_DCLK];
  end

  // =====================================================
  // Configuration store
  logic [NLOC-1:0] loc_mask_r [2*NMC]; // Local-input mask per term
  logic [NFB-1:0] fb_mask_r [2*NMC]; // Feedback mask per term
  cfg_t mc_cfg_r [NMC]; // Clear, clock, expander count
  cfg_t clr_cfg_r; // Clear sources and inversion
  cfg_t io_cfg_r; // I/O cell register setup
  logic mode_r; // Product-term mode enable
  logic [NLOC-1:0] loc_mask_nxt [2*NMC];
  logic [NFB-1:0] fb_mask_nxt [2*NMC];
  cfg_t mc_cfg_nxt [NMC];
  cfg_t clr_cfg_nxt;
  cfg_t io_cfg_nxt;
  logic mode_nxt;
  logic done_wr; // Configuration finished strobe
  logic misc_wr; // Write to the misc group

  // Write decode
  always_comb begin
    loc_mask_nxt = loc_mask_r;
    fb_mask_nxt = fb_mask_r;
    mc_cfg_nxt = mc_cfg_r;
    clr_cfg_nxt = clr_cfg_r;
    io_cfg_nxt = io_cfg_r;
    mode_nxt = mode_r;
    misc_wr = wr_en && addr[6:5] == `A_CFG_GRP && addr[4];
    done_wr = misc_wr && addr[3:0] == `A_CFG_DONE;
    if (wr_en && addr[6:5] == `A_TERM_LOC) begin
      loc_mask_nxt[addr[4:0]] = wr_data[NLOC-1:0]; // [R2]
    end
    if (wr_en && addr[6:5] == `A_TERM_FB) begin
      fb_mask_nxt[addr[4:0]] = wr_data[NFB-1:0]; // [R3]
    end
    if (wr_en && addr[6:5] == `A_CFG_GRP && !addr[4]) begin
      mc_cfg_nxt[addr[3:0]] = wr_data[7:0];
    end
    if (misc_wr && addr[3:0] == `A_CLR_CFG) begin
      clr_cfg_nxt = wr_data[7:0];
    end
    if (misc_wr && addr[3:0] == `A_IO_CFG) begin
      io_cfg_nxt = wr_data[7:0];
    end
    if (misc_wr && addr[3:0] == `A_BLK_CTRL) begin
      mode_nxt = wr_data[`BC_PT_MODE]; // [R1]
    end
  end

  // Store registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2*NMC; i++) begin
        loc_mask_r[i] <= '0;
        fb_mask_r[i] <= '0;
      end
      for (int i = 0; i < NMC; i++) begin
        mc_cfg_r[i] <= `RST_CFG;
      end
      clr_cfg_r <= `RST_CFG;
      io_cfg_r <= `RST_CFG;
      mode_r <= 1'b0;
    end else begin
      loc_mask_r <= loc_mask_nxt;
      fb_mask_r <= fb_mask_nxt;
      mc_cfg_r <= mc_cfg_nxt;
      clr_cfg_r <= clr_cfg_nxt;
      io_cfg_r <= io_cfg_nxt;
      mode_r <= mode_nxt;
    end
  end

  // =====================================================
  // The two block clears
  logic clr_a; // Clear A after inversion
  logic clr_b; // Clear B after inversion
  logic raw_a; // Clear A source
  logic raw_b; // Clear B source

  // Source pick then optional inversion
  always_comb begin
    if (clr_cfg_r[`CC_LOC_A]) begin
      raw_a = ctrl_in[0]; // [R6]
    end else begin
      raw_a = glb[clr_cfg_r[`CC_GSEL_A]]; // [R6]
    end
    if (clr_cfg_r[`CC_LOC_B]) begin
      raw_b = ctrl_in[1];
    end else begin
      raw_b = glb[clr_cfg_r[`CC_GSEL_B]];
    end
    clr_a = raw_a ^ clr_cfg_r[`CC_INV_A]; // [R8]
    clr_b = raw_b ^ clr_cfg_r[`CC_INV_B]; // [R8]
  end

  // =====================================================
  // Macrocells and expander chains
  logic [NT-1:0] term_in; // Local inputs plus feedback
  logic [NMC-1:0] term_or; // Own two-term OR per cell
  logic [NMC-1:0] exp_or; // Borrowed terms per cell

  // Feedback of the first cells into every term
  always_comb begin
    term_in = {mc_out[NFB-1:0], local_in}; // [R3]
  end

  for (genvar m = 0; m < NMC; m++) begin : g_mc
    logic cap; // Selected clock edge
    logic clr; // Selected clear or block off
    clr_sel_e sel; // Clear choice

    // Borrow up to fifteen neighbour pairs
    always_comb begin
      exp_or[m] = 1'b0;
      for (int j = 1; j < NMC; j++) begin
        if (j <= int'(mc_cfg_r[m][`MC_EXP_F])) begin
          exp_or[m] = exp_or[m] | term_or[(m + j) % NMC]; // [R10]
        end
      end
    end

    // Clock and clear steering
    always_comb begin
      sel = clr_sel_e'(mc_cfg_r[m][`MC_CLR_F]);
      cap = clk_edge[mc_cfg_r[m][`MC_CLK_F]]; // [R11]
      case (sel)
        CLR_A: clr = clr_a; // [R7]
        CLR_B: clr = clr_b; // [R7]
        default: clr = 1'b0; // [R7]
      endcase
      if (!mode_r) begin
        clr = 1'b1; // [R1]
      end
    end

    // One macrocell
    pterm_cell #(
      .NT(NT)
    ) u_cell (
      .clock(clock),
      .nrst(nrst),
      .term_in(term_in),
      .mask0({fb_mask_r[2*m], loc_mask_r[2*m]}),
      .mask1({fb_mask_r[2*m+1], loc_mask_r[2*m+1]}),
      .exp_in(exp_or[m]),
      .cap(cap),
      .clr(clr),
      .term_or(term_or[m]),
      .q_r(mc_out[m]) // [R5]
    );
  end

  // =====================================================
  // I/O cell register
  logic io_nxt;
  logic io_edge; // Selected clock edge for the I/O register
  logic io_d; // Data from the chosen macrocell

  // Power-up load, clear only when starting low
  always_comb begin
    io_edge = clk_edge[io_cfg_r[`IO_CLK_F]];
    io_d = mc_out[io_cfg_r[`IO_SRC_F]];
    if (done_wr) begin
      io_nxt = io_cfg_nxt[`IO_PU_HIGH]; // [R12]
    end else if (!io_cfg_r[`IO_PU_HIGH] && io_cfg_r[`IO_USE_CLR] // [R14]
                 && clr_a) begin
      io_nxt = 1'b0; // [R13]
    end else if (io_edge) begin
      io_nxt = io_d; // [R14]
    end else begin
      io_nxt = io_reg_out;
    end
  end

  // I/O register stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      io_reg_out <= 1'b0;
    end else begin
      io_reg_out <= io_nxt;
    end
  end

  // =====================================================
  // Read port
  word_t rd_nxt;

  // Read mux, zero outside the answer cycle
  always_comb begin
    rd_nxt = `RST_WORD;
    if (rd_en) begin
      case (addr[6:5])
        `A_TERM_LOC: rd_nxt[NLOC-1:0] = loc_mask_r[addr[4:0]];
        `A_TERM_FB: rd_nxt[NFB-1:0] = fb_mask_r[addr[4:0]];
        `A_CFG_GRP: begin
          if (!addr[4]) begin
            rd_nxt[7:0] = mc_cfg_r[addr[3:0]];
          end else begin
            case (addr[3:0])
              `A_CLR_CFG: rd_nxt[7:0] = clr_cfg_r;
              `A_IO_CFG: rd_nxt[7:0] = io_cfg_r;
              `A_BLK_CTRL: rd_nxt[0] = mode_r;
              `A_MC_STAT: rd_nxt[NMC-1:0] = mc_out; // [R5]
              `A_IO_STAT: rd_nxt[0] = io_reg_out;
              default: rd_nxt = `RST_WORD;
            endcase
          end
        end
        default: rd_nxt = `RST_WORD;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data <= `RST_WORD;
    end else begin
      rd_data <= rd_nxt;
    end
  end

  // =====================================================
  // Checks
  // Config done loads the stored power-up level
  AST_IO_LOAD: assert property (@(posedge clock) // [R12]
    disable iff (!nrst)
    done_wr |=> io_reg_out == $past(io_cfg_r[`IO_PU_HIGH]))
    else $error("power-up level not loaded");
  // Start-low register follows clear A when enabled
  AST_IO_CLR: assert property (@(posedge clock) // [R13]
    disable iff (!nrst)
    !done_wr && !io_cfg_r[`IO_PU_HIGH] && io_cfg_r[`IO_USE_CLR]
    && clr_a |=> !io_reg_out)
    else $error("start-low register not cleared");
  // Start-high register moves only on its own edge
  AST_IO_NOCLR: assert property (@(posedge clock) // [R14]
    disable iff (!nrst)
    !done_wr && io_cfg_r[`IO_PU_HIGH] && !io_edge
    |=> $stable(io_reg_out))
    else $error("start-high register moved");
  // A block left off holds every cell at zero
  AST_BLK_OFF: assert property (@(posedge clock) // [R1]
    disable iff (!nrst)
    !mode_r |=> mc_out == '0)
    else $error("disabled block drives macrocells");
  // Local clear source reaches cell 0
  AST_CLR_PIN: assert property (@(posedge clock) // [R6] [R8]
    disable iff (!nrst)
    clr_cfg_r[`CC_LOC_A] && (ctrl_in[0] ^ clr_cfg_r[`CC_INV_A])
    && mc_cfg_r[0][`MC_CLR_F] == CLR_A |=> !mc_out[0])
    else $error("clear A did not reach cell");
  // Global clear source reaches the last cell
  AST_CLR_GLB: assert property (@(posedge clock) // [R6] [R8]
    disable iff (!nrst)
    !clr_cfg_r[`CC_LOC_B]
    && (glb[clr_cfg_r[`CC_GSEL_B]] ^ clr_cfg_r[`CC_INV_B])
    && mc_cfg_r[NMC-1][`MC_CLR_F] == CLR_B |=> !mc_out[NMC-1])
    else $error("clear B did not reach cell");
  // Without clear or edge a running cell holds
  AST_CAP_PIN: assert property (@(posedge clock) // [R11]
    disable iff (!nrst)
    mode_r && mc_cfg_r[0][`MC_CLR_F] == CLR_NONE
    && !clk_edge[mc_cfg_r[0][`MC_CLK_F]] |=> $stable(mc_out[0]))
    else $error("cell moved without its edge");
  // One pin pulse makes a single-cycle edge
  AST_EDGE_PULSE: assert property (@(posedge clock) // [R11]
    disable iff (!nrst)
    clk_edge[0] |=> !clk_edge[0])
    else $error("clock edge stretched");
  // One borrowed set wraps round to the first cell
  AST_EXP_WRAP: assert property (@(posedge clock) // [R10]
    disable iff (!nrst)
    mc_cfg_r[NMC-1][`MC_EXP_F] == 4'h1 |-> exp_or[NMC-1] == term_or[0])
    else $error("expander chain wrong");
  // Status reads return the registers as they stood
  AST_RD_STAT: assert property (@(posedge clock) // [R5]
    disable iff (!nrst)
    rd_en && addr == `A_MC_STAT_FULL
    |=> rd_data[NMC-1:0] == $past(mc_out))
    else $error("status read wrong");
  AST_RD_IO: assert property (@(posedge clock) // [R12]
    disable iff (!nrst)
    rd_en && addr == {`A_CFG_GRP, 1'b1, `A_IO_STAT}
    |=> rd_data == {31'h0, $past(io_reg_out)})
    else $error("I/O status read wrong");
  // Read data fall back to zero outside the answer
  AST_RD_IDLE: assert property (@(posedge clock) disable iff (!nrst)
    !rd_en |=> rd_data == '0)
    else $error("read data outside answer cycle");
endmodule

// [src/ptm_params.svh]
// Constants for the product-term array block: map, fields, resets
// =====================================================================
// Contract
// [R1] Each array block configurable on its own
// [R2] Thirty-two inputs from adjacent local interconnect
// [R3] Nine macrocell outputs fed back locally
// [R4] Controls from clock pins, globals, local inputs
// [R5] Sixteen macrocells, two terms plus register each
// [R6] Exactly two clears from globals and local
// [R7] Each macrocell picks clear A, B or none
// [R8] Either clear may be inverted in block
// [R9] OR gate takes up to thirty-two terms
// [R10] Up to fifteen borrowed sets of two terms
// [R11] Four dedicated clock inputs reach the block
// [R12] I/O cell register starts high or low
// [R13] Start-low I/O register clearable at any time
// [R14] Start-high I/O register ignores clear and preset
// [R15] Register captures OR on edge; clear first
// =====================================================================
`ifndef PTM_PARAMS_SVH
`define PTM_PARAMS_SVH

// Sizes
`define NUM_MC 16
`define NUM_LOC 32
`define NUM_FB 9
`define NUM_DCLK 4
`define NUM_GLB 4
`define NUM_TERM 41

// Register word addresses
`define A_TERM_LOC 2'b00
`define A_TERM_FB 2'b01
`define A_CFG_GRP 2'b10
`define A_CLR_CFG 4'h0
`define A_IO_CFG 4'h1
`define A_CFG_DONE 4'h2
`define A_BLK_CTRL 4'h3
`define A_MC_STAT 4'h4
`define A_IO_STAT 4'h5
`define A_MC_STAT_FULL 7'h54

// Macrocell configuration fields
`define MC_CLR_F 1:0
`define MC_CLK_F 3:2
`define MC_EXP_F 7:4

// Clear configuration fields
`define CC_INV_A 0
`define CC_INV_B 1
`define CC_LOC_A 2
`define CC_LOC_B 3
`define CC_GSEL_A 5:4
`define CC_GSEL_B 7:6

// I/O cell configuration fields
`define IO_PU_HIGH 0
`define IO_USE_CLR 1
`define IO_CLK_F 3:2
`define IO_SRC_F 7:4

// Block control fields
`define BC_PT_MODE 0

// Reset values
`define RST_CFG 8'h00
`define RST_WORD 32'h0000_0000

`endif

// [src/ptm_pkg.sv]
// Types shared by the product-term array block
package ptm_pkg;
  // Clear choice per macrocell
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_A = 2'b01,
    CLR_B = 2'b10,
    CLR_RSV = 2'b11
  } clr_sel_e;
  // Bus data word
  typedef logic [31:0] word_t;
  // Bus word address
  typedef logic [6:0] addr_t;
  // Eight-bit configuration byte
  typedef logic [7:0] cfg_t;
endpackage

// [src/pterm_cell.sv]
// One macrocell: two product terms, expander input, register
`timescale 1ns/1ns
`include "ptm_params.svh"
module pterm_cell #(
  parameter int NT = `NUM_TERM
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [NT-1:0] term_in,
  input wire logic [NT-1:0] mask0,
  input wire logic [NT-1:0] mask1,
  input wire logic exp_in,
  input wire logic cap,
  input wire logic clr,
  output logic term_or,
  output logic q_r
);
  // Term values and register next value
  logic t0;
  logic t1;
  logic d;
  logic q_nxt;

  // =====================================================
  // Product terms and OR gate
  // Empty mask means an unused term that reads as zero
  always_comb begin
    t0 = (|mask0) & (&(term_in | ~mask0));
    t1 = (|mask1) & (&(term_in | ~mask1));
    term_or = t0 | t1;
    d = term_or | exp_in; // [R9]
    // Clear beats capture
    if (clr) begin
      q_nxt = 1'b0; // [R15]
    end else if (cap) begin
      q_nxt = d; // [R15]
    end else begin
      q_nxt = q_r;
    end
  end

  // Register stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // =====================================================
  // Checks
  AST_CLR_WINS: assert property (@(posedge clock) disable iff (!nrst) // [R7]
    clr |=> !q_r) else $error("clear did not win");
  AST_CAPTURE: assert property (@(posedge clock) disable iff (!nrst) // [R15]
    !clr && cap |=> q_r == $past(d))
    else $error("capture lost");
  AST_HOLD: assert property (@(posedge clock) disable iff (!nrst) // [R15]
    !clr && !cap |=> $stable(q_r))
    else $error("register moved without edge");
endmodule

// [verif/fabric_model.sv]
// Fabric model: drives local, clear-source and clock-pin inputs
`timescale 1ns/1ns
module fabric_model (
  input wire logic clock,
  output logic [31:0] local_in,
  output logic [1:0] ctrl_in,
  output logic [3:0] ded_clk_pin,
  output logic [3:0] global_pin
);
  // Quiet fabric at time zero
  initial begin
    local_in = 32'h0000_0000;
    ctrl_in = 2'h0;
    ded_clk_pin = 4'h0;
    global_pin = 4'h0;
  end

  // Change sources just after an edge
  task automatic drive(input logic [31:0] l, input logic [1:0] c,
                       input logic [3:0] g);
    @(posedge clock);
    local_in <= l;
    ctrl_in <= c;
    global_pin <= g;
  endtask

  // One pin pulse, two cycles high; pins stand low between pulses
  task automatic pulse(input int i);
    @(posedge clock);
    ded_clk_pin[i] <= 1'b1;
    repeat (2) @(posedge clock);
    ded_clk_pin[i] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench for the product-term array block
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  import ptm_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  addr_t addr = 7'h00;
  word_t wr_data = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  word_t rd_data;
  logic [31:0] local_in;
  logic [1:0] ctrl_in;
  logic [3:0] ded_clk_pin;
  logic [3:0] global_pin;
  logic [15:0] mc_out;
  logic io_reg_out;
  int err_count = 0;
  int tests_run = 0;

  always #20 clock = ~clock;

  ptm_array_block ptm_array_block_inst (.clock(clock), .nrst(nrst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .local_in(local_in), .ctrl_in(ctrl_in),
    .ded_clk_pin(ded_clk_pin), .global_pin(global_pin),
    .mc_out(mc_out), .io_reg_out(io_reg_out));
  fabric_model fabric_model_inst (.clock(clock), .local_in(local_in),
    .ctrl_in(ctrl_in), .ded_clk_pin(ded_clk_pin), .global_pin(global_pin));

  // Bus write, one strobe cycle
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // Bus read; answer stands one cycle, then returns to zero
  task automatic chk_rd(input string n, input addr_t a, input word_t e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    `CHK(n, e, rd_data)
    @(negedge clock);
    `CHK("rd_idle", 32'h0000_0000, rd_data)
  endtask

  // Cell outputs by status read and at the port
  task automatic chk_mc(input logic [15:0] e);
    chk_rd("mc_stat", 7'h54, {16'h0000, e});
    `CHK("mc_out", e, mc_out)
  endtask

  // I/O register by status read and at the port
  task automatic chk_io(input logic e);
    chk_rd("io_stat", 7'h55, {31'h0, e});
    `CHK("io_reg_out", e, io_reg_out)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    results();
  end

  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    // Reset state, unmapped and write-only places read zero
    chk_mc(16'h0000);
    chk_rd("unmapped", 7'h7f, 32'h0000_0000);
    chk_rd("cfg_done", 7'h52, 32'h0000_0000);
    // Mask widths: 32 local, 9 feedback, 8-bit cell config
    wr(7'h00, 32'hffff_ffff);
    chk_rd("loc_mask", 7'h00, 32'hffff_ffff);
    wr(7'h20, 32'hffff_ffff);
    chk_rd("fb_mask", 7'h20, 32'h0000_01ff);
    wr(7'h40, 32'hffff_ffff);
    chk_rd("cell_cfg", 7'h40, 32'h0000_00ff);
    wr(7'h20, 32'h0);
    wr(7'h40, 32'h0);
    // Cell terms: c0=L0, c1=fb0, c2=L1&L2, c3=L31, c15 borrows c0
    wr(7'h00, 32'h0000_0001);
    wr(7'h22, 32'h0000_0001);
    wr(7'h04, 32'h0000_0006);
    wr(7'h07, 32'h8000_0000);
    wr(7'h4f, 32'h0000_0010);
    fabric_model_inst.drive(32'h8000_0003, 2'b00, 4'h0);
    fabric_model_inst.pulse(0);
    chk_mc(16'h0000);
    wr(7'h53, 32'h0000_0001);
    fabric_model_inst.pulse(0);
    chk_mc(16'h8009);
    fabric_model_inst.pulse(0);
    chk_mc(16'h800b);
    fabric_model_inst.drive(32'h0000_0007, 2'b00, 4'h0);
    fabric_model_inst.pulse(0);
    chk_mc(16'h8007);
    // Cell 2 moves to clock pin 3
    wr(7'h42, 32'h0000_000c);
    fabric_model_inst.drive(32'h0, 2'b00, 4'h0);
    fabric_model_inst.pulse(0);
    chk_mc(16'h0006);
    fabric_model_inst.pulse(3);
    chk_mc(16'h0002);
    fabric_model_inst.pulse(0);
    chk_mc(16'h0000);
    // Clears: c0 on A, c15 on B, sources from local controls
    wr(7'h40, 32'h0000_0001);
    wr(7'h4f, 32'h0000_0012);
    wr(7'h50, 32'h0000_000c);
    fabric_model_inst.drive(32'h1, 2'b00, 4'h0);
    fabric_model_inst.pulse(0);
    chk_mc(16'h8001);
    fabric_model_inst.drive(32'h1, 2'b01, 4'h0);
    cyc(2);
    chk_mc(16'h8000);
    fabric_model_inst.drive(32'h1, 2'b10, 4'h0);
    cyc(2);
    chk_mc(16'h0000);
    // Both clears inverted
    wr(7'h50, 32'h0000_000f);
    fabric_model_inst.drive(32'h1, 2'b11, 4'h0);
    fabric_model_inst.pulse(0);
    chk_mc(16'h8001);
    fabric_model_inst.drive(32'h1, 2'b00, 4'h0);
    cyc(2);
    chk_mc(16'h0000);
    // Clears from globals: A on global 0, B on global 1
    wr(7'h50, 32'h0000_0040);
    fabric_model_inst.pulse(0);
    chk_mc(16'h8001);
    fabric_model_inst.drive(32'h1, 2'b00, 4'h2);
    cyc(4);
    chk_mc(16'h0001);
    fabric_model_inst.drive(32'h1, 2'b00, 4'h0);
    // I/O register starting high ignores clear A
    wr(7'h51, 32'h0000_0003);
    wr(7'h52, 32'h0000_0000);
    chk_io(1'b1);
    fabric_model_inst.drive(32'h1, 2'b00, 4'h1);
    cyc(4);
    chk_io(1'b1);
    // I/O register starting low, loads cell 0, then cleared
    fabric_model_inst.drive(32'h1, 2'b00, 4'h0);
    wr(7'h51, 32'h0000_0002);
    wr(7'h52, 32'h0000_0000);
    chk_io(1'b0);
    fabric_model_inst.pulse(0);
    fabric_model_inst.pulse(0);
    chk_io(1'b1);
    fabric_model_inst.drive(32'h1, 2'b00, 4'h1);
    cyc(4);
    chk_io(1'b0);
    // Every local input reaches a term: cell 4 ANDs all 32, pin 1
    fabric_model_inst.drive(32'h0, 2'b00, 4'h0);
    wr(7'h50, 32'h0000_00e0);
    wr(7'h08, 32'hffff_ffff);
    wr(7'h44, 32'h0000_0004);
    wr(7'h2a, 32'h0000_0010);
    wr(7'h45, 32'h0000_0008);
    for (int b = 0; b < 32; b++) begin
      fabric_model_inst.drive(~(32'h1 << b), 2'b00, 4'h0);
      fabric_model_inst.pulse(1);
      `CHK("cell4", 1'b0, mc_out[4])
    end
    // Cell 5 reads cell 4 back through feedback, on pin 2
    fabric_model_inst.drive(32'hffff_ffff, 2'b00, 4'h0);
    fabric_model_inst.pulse(1);
    fabric_model_inst.pulse(2);
    chk_mc(16'h8032);
    // Clear A from global 2, clear B from global 3
    fabric_model_inst.pulse(0);
    chk_mc(16'h8039);
    fabric_model_inst.drive(32'hffff_ffff, 2'b00, 4'h4);
    cyc(4);
    chk_mc(16'h8038);
    fabric_model_inst.drive(32'hffff_ffff, 2'b00, 4'hc);
    cyc(4);
    chk_mc(16'h0038);
    // Reset in mid-run returns cells and setup to zero
    @(posedge clock);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    chk_mc(16'h0000);
    chk_rd("clr_cfg", 7'h50, 32'h0000_0000);
    chk_io(1'b0);
    results();
  end
endmodule
